// >>> hdl/aiss_pkg.sv
// constants, state type and helpers for the amplifier host sequencer
// assumes pclk at 40 MHz and an APB master doing aligned 32-bit accesses
// What this block does
// - amplifier inputs low until supplies are good
// - reset low, clocks on, 100 us first
// - wait 13.5 ms after reset release
// - wait 10 us after power stage supply
// - coefficients, dynamics, bank, rest, then exit
// - only volume, mute, shutdown while streaming
// - no shutdown change inside power-on wait
// - clocks stable 50 ms before shutdown change
// - enter shutdown by writing 0x40 to 0x05
// - after entry wait 1 ms plus 1.3 stop
// - reconfigure after 50 ms clocks, remaining registers
// - leave shutdown by writing 0x00 to 0x05
// - after exit wait 1 ms plus 1.3 start
// - allow 50 ms auto-detect before commands
// - 240 ms plus 1.3 start after first trim
// - inputs stay valid 2 us after reset low
package aiss_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int T_DV_RH_US = 100;
  localparam int T_PVDD_I2C_US = 10;
  localparam int T_RL_DV_US = 2;
  localparam int T_RH_I2C_US = 13_500;
  localparam int T_MS_US = 1_000;
  localparam int T_AUTODET_MS = 50;
  localparam int T_POR_MS = 240;
  localparam int T_SD_MS = 1;
  localparam int SCALE_NUM = 13;
  localparam int SCALE_DEN = 10;

  // least times round up to whole cycles
  function automatic int us_cyc(input int us);
    return int'((longint'(us) * CLK_HZ + 64'd999_999) / 64'd1_000_000);
  endfunction

  localparam int CYC_DV_RH = us_cyc(T_DV_RH_US);
  localparam int CYC_PVDD = us_cyc(T_PVDD_I2C_US);
  localparam int CYC_RL_DV = us_cyc(T_RL_DV_US);
  localparam int CYC_RH_I2C = us_cyc(T_RH_I2C_US);
  localparam int CYC_PER_MS = us_cyc(T_MS_US);

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_PERIOD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int STAT_REFUSED_BIT = 5;
  localparam logic [7:0] RST_TSTART_MS = 8'h00;
  localparam logic [7:0] RST_TSTOP_MS = 8'h00;

  localparam logic [7:0] SUB_SHUTDOWN = 8'h05;
  localparam logic [7:0] VAL_SD_ENTER = 8'h40;
  localparam logic [7:0] VAL_SD_EXIT = 8'h00;
  localparam logic [7:0] SUB_MUTE = 8'h06;
  localparam logic [7:0] SUB_VOL_LO = 8'h07;
  localparam logic [7:0] SUB_VOL_HI = 8'h0A;
  localparam logic [7:0] SUB_BQ_LO = 8'h29;
  localparam logic [7:0] SUB_BQ_HI = 8'h36;
  localparam logic [7:0] SUB_DRA_LO = 8'h3A;
  localparam logic [7:0] SUB_DRA_HI = 8'h3C;
  localparam logic [7:0] SUB_DRB_LO = 8'h40;
  localparam logic [7:0] SUB_DRB_HI = 8'h42;
  localparam logic [7:0] SUB_DRC = 8'h46;
  localparam logic [7:0] SUB_BANK = 8'h50;

  typedef enum logic [3:0] {
    ST_OFF, ST_PRE, ST_WAKE, ST_CFG, ST_SDCMD, ST_HOLD, ST_RUN, ST_DOWN
  } aiss_state_t;

  // configuration phase: 0 filters, 1 dynamics, 2 bank, 3 the rest
  function automatic logic [1:0] phase_of(input logic [7:0] sub);
    if (sub >= SUB_BQ_LO && sub <= SUB_BQ_HI) return 2'h0;
    if ((sub >= SUB_DRA_LO && sub <= SUB_DRA_HI) || (sub >= SUB_DRB_LO && sub <= SUB_DRB_HI)
        || sub == SUB_DRC) return 2'h1;
    if (sub == SUB_BANK) return 2'h2;
    return 2'h3;
  endfunction

  // writes with click and pop protection, allowed while streaming
  function automatic logic is_live(input logic [7:0] sub);
    return sub == SUB_MUTE || (sub >= SUB_VOL_LO && sub <= SUB_VOL_HI);
  endfunction

  // 1.3 times a period in ms, rounded up
  function automatic logic [9:0] scale13(input logic [7:0] t);
    logic [11:0] p;
    p = 12'(t) * 12'(SCALE_NUM) + 12'(SCALE_DEN - 1);
    return 10'(p / 12'(SCALE_DEN));
  endfunction
endpackage

// >>> hdl/aiss_host.sv
// host sequencer driving the amplifier reset, shutdown pin and clock gate,
// issuing register writes through an external I2C write engine
// assumes supply and clock-valid flags arrive asynchronously; i2c_done is on pclk
`timescale 1ns/1ps
module aiss_host
  import aiss_pkg::*;
#(
  parameter int CYC_RH_I2C_P = CYC_RH_I2C,
  parameter int CYC_PER_MS_P = CYC_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_ok,
  input wire logic pvdd_ok,
  input wire logic clk_ok,
  output logic amp_rst_n,
  output logic shutdown_n_pin,
  output logic i2s_clk_en,
  output logic i2c_req,
  output logic [7:0] i2c_sub,
  output logic [7:0] i2c_data,
  input wire logic i2c_done
);

  if (CYC_RH_I2C_P < 1 || CYC_RH_I2C_P >= 2 ** 20) begin : g_chk_rh
    $error("CYC_RH_I2C_P out of range");
  end
  if (CYC_PER_MS_P < 2 || CYC_PER_MS_P >= 2 ** 16) begin : g_chk_ms
    $error("CYC_PER_MS_P out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic supply_m, supply_s, pvdd_m, pvdd_s, clk_m, clk_s;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_m <= 1'b0;
      supply_s <= 1'b0;
      pvdd_m <= 1'b0;
      pvdd_s <= 1'b0;
      clk_m <= 1'b0;
      clk_s <= 1'b0;
    end else begin
      supply_m <= supply_ok;
      supply_s <= supply_m;
      pvdd_m <= pvdd_ok;
      pvdd_s <= pvdd_m;
      clk_m <= clk_ok;
      clk_s <= clk_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  aiss_state_t state_q, state_d;
  logic [19:0] cyc_q, cyc_d, rh_q, rh_d;
  logic [15:0] tick_q, tick_d, pv_q, pv_d;
  logic [7:0] stab_q, stab_d, rl_q, rl_d;
  logic [9:0] por_q, por_d, hold_q, hold_d;
  logic por_go_q, por_go_d, dir_q, dir_d;
  logic en_q, en_d, run_q, run_d, pend_q, pend_d, refused_q, refused_d;
  logic [7:0] csub_q, csub_d, cdat_q, cdat_d, tstart_q, tstart_d, tstop_q, tstop_d;
  logic [1:0] phase_q, phase_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic rst_q, rst_d, sdn_q, sdn_d, i2s_q, i2s_d;
  logic req_q, req_d;
  logic [7:0] sub_q, sub_d, dat_q, dat_d;
  logic tick, stab_ok, por_done, pv_ok, wr_take, ref_set, ref_clr, legal, can_sd;
  logic [9:0] hold_need, por_need;

  assign hold_need = 10'(T_SD_MS) + scale13(dir_q ? tstart_q : tstop_q);
  assign por_need = 10'(T_POR_MS) + scale13(tstart_q);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic: bus slave, timebase, sequencer
  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q;
    dir_d = dir_q;
    en_d = en_q;
    run_d = run_q;
    pend_d = pend_q;
    csub_d = csub_q;
    cdat_d = cdat_q;
    tstart_d = tstart_q;
    tstop_d = tstop_q;
    phase_d = phase_q;
    req_d = req_q;
    sub_d = sub_q;
    dat_d = dat_q;
    hold_d = hold_q;
    ref_set = 1'b0;
    ref_clr = 1'b0;
    legal = 1'b0;
    // free-running millisecond timebase shared by the auto-detect, power-on and shutdown-hold waits
    tick = tick_q == 16'(CYC_PER_MS_P - 1);
    tick_d = tick ? 16'h0000 : tick_q + 16'h0001;
    // ticks are not aligned to a wait's start, so each wait needs one extra tick
    stab_ok = stab_q > 8'(T_AUTODET_MS);
    por_done = por_q > por_need;
    pv_ok = pv_q >= 16'(CYC_PVDD);
    can_sd = !pend_q && !req_q && stab_ok && por_done;
    // clock stability counts only while clocks are enabled and valid
    if (!(clk_s && i2s_q)) begin
      stab_d = 8'h00;
    end else if (tick && stab_q != 8'hFF) begin
      stab_d = stab_q + 8'h01;
    end else begin
      stab_d = stab_q;
    end
    // power-stage supply age, saturating
    if (!pvdd_s) begin
      pv_d = 16'h0000;
    end else if (!pv_ok) begin
      pv_d = pv_q + 16'h0001;
    end else begin
      pv_d = pv_q;
    end
    // power-on wait runs once per supply ramp, from the first reset release
    por_go_d = supply_s && por_go_q;
    if (!supply_s) begin
      por_d = 10'h000;
    end else if (por_go_q && tick && por_q != 10'h3FF) begin
      por_d = por_q + 10'h001;
    end else begin
      por_d = por_q;
    end
    // bus slave: one wait state, answer registered
    pready_d = psel && penable && !pready_q;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    wr_take = psel && penable && pready_q && pwrite;
    if (pready_d) begin
      unique case (paddr)
        REG_CTRL: prdata_d = {30'h0, run_q, en_q};
        REG_CMD: prdata_d = {15'h0, pend_q, csub_q, cdat_q};
        REG_PERIOD: prdata_d = {16'h0, tstop_q, tstart_q};
        REG_STATUS: prdata_d = {23'h0, req_q, por_done, stab_ok, refused_q, pend_q, state_q};
        default: begin
          prdata_d = 32'h0000_0000;
          pslverr_d = 1'b1;
        end
      endcase
    end
    if (wr_take) begin
      unique case (paddr)
        REG_CTRL: begin
          en_d = pwdata[CTRL_EN_BIT];
          run_d = pwdata[CTRL_RUN_BIT];
        end
        REG_CMD: begin
          if (pend_q) begin
            ref_set = 1'b1;
          end else begin
            pend_d = 1'b1;
            csub_d = pwdata[15:8];
            cdat_d = pwdata[7:0];
          end
        end
        REG_PERIOD: begin
          tstart_d = pwdata[7:0];
          tstop_d = pwdata[15:8];
        end
        REG_STATUS: ref_clr = pwdata[STAT_REFUSED_BIT];
        default: ;
      endcase
    end
    // request held until the write engine reports completion
    if (req_q && i2c_done) begin
      req_d = 1'b0;
    end
    // queued register write, sent only once auto-detect has had its time
    if ((state_q == ST_CFG || state_q == ST_RUN) && pend_q && !req_q && stab_ok) begin
      if (state_q == ST_RUN) begin
        legal = is_live(csub_q);
      end else begin
        legal = csub_q != SUB_SHUTDOWN && phase_of(csub_q) >= phase_q;
      end
      pend_d = 1'b0;
      ref_set = !legal;
      if (legal) begin
        req_d = 1'b1;
        sub_d = csub_q;
        dat_d = cdat_q;
        if (state_q == ST_CFG) begin
          phase_d = phase_of(csub_q);
        end
      end
    end
    unique case (state_q)
      ST_OFF: begin
        phase_d = 2'h0;
        if (en_q && supply_s) begin
          state_d = ST_PRE;
          cyc_d = 20'h0;
        end
      end
      ST_PRE: begin
        // the 100 us only counts while clocks are valid
        if (!clk_s) begin
          cyc_d = 20'h0;
        end else if (cyc_q == 20'(CYC_DV_RH - 1)) begin
          state_d = ST_WAKE;
          cyc_d = 20'h0;
          por_go_d = supply_s;
        end else begin
          cyc_d = cyc_q + 20'h1;
        end
      end
      ST_WAKE: begin
        if (cyc_q >= 20'(CYC_RH_I2C_P - 1) && pv_ok) begin
          state_d = ST_CFG;
        end else if (cyc_q < 20'(CYC_RH_I2C_P - 1)) begin
          cyc_d = cyc_q + 20'h1;
        end
      end
      ST_CFG: begin
        if (run_q && can_sd) begin
          state_d = ST_SDCMD;
          dir_d = 1'b1;
          req_d = 1'b1;
          sub_d = SUB_SHUTDOWN;
          dat_d = VAL_SD_EXIT;
        end
      end
      ST_RUN: begin
        if (!run_q && can_sd) begin
          state_d = ST_SDCMD;
          dir_d = 1'b0;
          req_d = 1'b1;
          sub_d = SUB_SHUTDOWN;
          dat_d = VAL_SD_ENTER;
        end
      end
      ST_SDCMD: begin
        // no timeout: an exit may sit unserviced for a long time
        if (i2c_done) begin
          state_d = ST_HOLD;
          hold_d = 10'h000;
        end
      end
      ST_HOLD: begin
        if (tick && hold_q != 10'h3FF) begin
          hold_d = hold_q + 10'h001;
        end
        if (hold_q > hold_need) begin
          state_d = dir_q ? ST_RUN : ST_CFG;
        end
      end
      ST_DOWN: begin
        if (cyc_q == 20'(CYC_RL_DV - 1)) begin
          state_d = ST_OFF;
        end else begin
          cyc_d = cyc_q + 20'h1;
        end
      end
    endcase
    // disable or supply loss: reset first, inputs released later
    if (state_q != ST_OFF && state_q != ST_DOWN && (!en_q || !supply_s)) begin
      state_d = ST_DOWN;
      cyc_d = 20'h0;
      req_d = 1'b0;
      pend_d = 1'b0;
    end
    // set wins over clear
    refused_d = ref_set || (refused_q && !ref_clr);
    // pins follow the next state so they leave a flip-flop
    rst_d = state_d inside {ST_WAKE, ST_CFG, ST_SDCMD, ST_HOLD, ST_RUN};
    sdn_d = state_d != ST_OFF;
    i2s_d = state_d != ST_OFF;
    // cycle counts since reset edges, watched by the checks below
    rh_d = !rst_q ? 20'h0 : (rh_q == 20'hFFFFF ? rh_q : rh_q + 20'h1);
    rl_d = rst_q ? 8'h00 : (rl_q == 8'hFF ? rl_q : rl_q + 8'h01);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_OFF;
      cyc_q <= 20'h0;
      tick_q <= 16'h0000;
      pv_q <= 16'h0000;
      stab_q <= 8'h00;
      por_q <= 10'h000;
      por_go_q <= 1'b0;
      hold_q <= 10'h000;
      dir_q <= 1'b0;
      en_q <= 1'b0;
      run_q <= 1'b0;
      pend_q <= 1'b0;
      refused_q <= 1'b0;
      csub_q <= 8'h00;
      cdat_q <= 8'h00;
      tstart_q <= RST_TSTART_MS;
      tstop_q <= RST_TSTOP_MS;
      phase_q <= 2'h0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      rst_q <= 1'b0;
      sdn_q <= 1'b0;
      i2s_q <= 1'b0;
      req_q <= 1'b0;
      sub_q <= 8'h00;
      dat_q <= 8'h00;
      rh_q <= 20'h0;
      rl_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      tick_q <= tick_d;
      pv_q <= pv_d;
      stab_q <= stab_d;
      por_q <= por_d;
      por_go_q <= por_go_d;
      hold_q <= hold_d;
      dir_q <= dir_d;
      en_q <= en_d;
      run_q <= run_d;
      pend_q <= pend_d;
      refused_q <= refused_d;
      csub_q <= csub_d;
      cdat_q <= cdat_d;
      tstart_q <= tstart_d;
      tstop_q <= tstop_d;
      phase_q <= phase_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      rst_q <= rst_d;
      sdn_q <= sdn_d;
      i2s_q <= i2s_d;
      req_q <= req_d;
      sub_q <= sub_d;
      dat_q <= dat_d;
      rh_q <= rh_d;
      rl_q <= rl_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign amp_rst_n = rst_q;
  assign shutdown_n_pin = sdn_q;
  assign i2s_clk_en = i2s_q;
  assign i2c_req = req_q;
  assign i2c_sub = sub_q;
  assign i2c_data = dat_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_off_low;
    state_q == ST_OFF |-> !rst_q && !sdn_q && !i2s_q;
  endproperty
  a_off_low: assert property (p_off_low) else $error("inputs not low when off");

  property p_pre_hold;
    $rose(rst_q) |-> $past(state_q) == ST_PRE && $past(cyc_q) == 20'(CYC_DV_RH - 1)
      && $past(sdn_q) && $past(i2s_q);
  endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("reset released early");

  property p_rh_wait;
    $rose(req_q) |-> rh_q >= 20'(CYC_RH_I2C_P) && pv_q >= 16'(CYC_PVDD);
  endproperty
  a_rh_wait: assert property (p_rh_wait) else $error("I2C too soon after reset");

  property p_phase;
    // the new write may not fall back to an earlier phase than the one before it
    $rose(req_q) && state_q == ST_CFG |-> phase_of(sub_q) == phase_q
      && phase_of(sub_q) >= $past(phase_q) && sub_q != SUB_SHUTDOWN;
  endproperty
  a_phase: assert property (p_phase) else $error("config order broken");

  property p_live;
    $rose(req_q) && state_q == ST_RUN |-> is_live(sub_q);
  endproperty
  a_live: assert property (p_live) else $error("config write while streaming");

  property p_sd_cond;
    // judged on the values the decision used, a clock drop may clear stab_q at that edge
    $rose(state_q == ST_SDCMD) |-> req_q && $past(stab_q) > 8'(T_AUTODET_MS)
      && $past(por_q) > $past(por_need);
  endproperty
  a_sd_cond: assert property (p_sd_cond) else $error("shutdown change too soon");

  property p_sd_enter;
    state_q == ST_SDCMD && req_q && !dir_q |-> sub_q == SUB_SHUTDOWN && dat_q == VAL_SD_ENTER;
  endproperty
  a_sd_enter: assert property (p_sd_enter) else $error("bad shutdown entry write");

  property p_sd_exit;
    state_q == ST_SDCMD && req_q && dir_q |-> sub_q == SUB_SHUTDOWN && dat_q == VAL_SD_EXIT;
  endproperty
  a_sd_exit: assert property (p_sd_exit) else $error("bad shutdown exit write");

  property p_hold;
    $past(state_q) == ST_HOLD && state_q inside {ST_RUN, ST_CFG}
      |-> $past(hold_q) > $past(hold_need) && !req_q;
  endproperty
  a_hold: assert property (p_hold) else $error("shutdown wait cut short");

  property p_stab;
    $rose(req_q) |-> $past(stab_q) > 8'(T_AUTODET_MS);
  endproperty
  a_stab: assert property (p_stab) else $error("command before auto-detect");

  property p_rl_valid;
    $fell(i2s_q) |-> rl_q >= 8'(CYC_RL_DV) && !rst_q;
  endproperty
  a_rl_valid: assert property (p_rl_valid) else $error("inputs dropped too soon");

endmodule

// >>> tb/aiss_amp_model.sv
// amplifier stand-in: takes register writes from the host sequencer and acknowledges them
// assumes i2c_req is a level held until the one-cycle i2c_done, all on pclk
`timescale 1ns/1ps
module aiss_amp_model
  import aiss_pkg::*;
(
  input wire logic pclk,
  input wire logic amp_rst_n,
  input wire logic i2c_req,
  input wire logic [7:0] i2c_sub,
  input wire logic [7:0] i2c_data,
  output logic i2c_done,
  output int viol
);
  int cnt = 0;
  logic live = 1'b0;
  initial i2c_done = 1'b0;
  initial viol = 0;
  ////////////////////////////////////////////////////////////
  // one write at a time; a cycle of rest after each done so a held req is not taken twice
  always @(posedge pclk) begin
    i2c_done <= 1'b0;
    if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      i2c_done <= 1'b1;
    end else if (i2c_req && !i2c_done) begin
      // exit answered late, as the part may leave it pending
      cnt <= (i2c_sub == SUB_SHUTDOWN && i2c_data == VAL_SD_EXIT) ? 300 : 3;
      if (!amp_rst_n)
        viol++;
      // while playing only mute, volume and shutdown are taken without clicks
      if (live && !(i2c_sub == SUB_SHUTDOWN || (i2c_sub >= SUB_MUTE && i2c_sub <= SUB_VOL_HI)))
        viol++;
      // no clock check: a shut-down part idles without clocks
      if (i2c_sub == SUB_SHUTDOWN)
        live <= (i2c_data == VAL_SD_EXIT);
    end
  end
endmodule

// >>> tb/tb.sv
// self-checking bench for the amplifier host sequencer
// assumes the amplifier stand-in in aiss_amp_model and shortened timing parameters
`timescale 1ns/1ps
module tb;
  import aiss_pkg::*;
  localparam int MS = 40;
  localparam int RH = 600;
  logic pclk, presetn, psel, penable, pwrite, supply_ok, pvdd_ok, clk_ok, i2c_done;
  logic pready, pslverr, amp_rst_n, shutdown_n_pin, i2s_clk_en, i2c_req, er;
  logic req_d = 1'b0;
  logic [7:0] paddr, i2c_sub, i2c_data;
  logic [31:0] pwdata, prdata, rd;
  int fails = 0, n_compared = 0, cyc = 0, n_done = 0, t_dn = 0, viol, seed = 12003;
  int t_rel, t0, t_pv, ts, tst, k;
  logic [15:0] exp_q[$], got_q[$];
  int t_q[$];
  logic [7:0] subs[7] = '{8'h29, 8'h36, 8'h3A, 8'h42, 8'h46, 8'h50, 8'h0E};

  aiss_host #(.CYC_RH_I2C_P(RH), .CYC_PER_MS_P(MS)) u_aiss_host (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_ok(supply_ok), .pvdd_ok(pvdd_ok), .clk_ok(clk_ok), .amp_rst_n(amp_rst_n),
    .shutdown_n_pin(shutdown_n_pin), .i2s_clk_en(i2s_clk_en), .i2c_req(i2c_req),
    .i2c_sub(i2c_sub), .i2c_data(i2c_data), .i2c_done(i2c_done));
  aiss_amp_model u_aiss_amp_model (.pclk(pclk), .amp_rst_n(amp_rst_n), .i2c_req(i2c_req),
    .i2c_sub(i2c_sub), .i2c_data(i2c_data), .i2c_done(i2c_done), .viol(viol));

  ////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    $display("Error watchdog expected end seen hang");
    tally_and_finish();
  end
  // log every write as it starts, with its cycle
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    req_d <= i2c_req;
    if (i2c_req && !req_d) begin
      got_q.push_back({i2c_sub, i2c_data});
      t_q.push_back(cyc);
    end
    if (i2c_done) begin
      n_done <= n_done + 1;
      t_dn <= cyc;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  // no fixed answer time assumed: the watchdog ends a dead bus
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_n(input int n);
    for (int j = 0; j < 30000 && n_done < n; j++) @(posedge pclk);
    @(posedge pclk);
  endtask
  // accepted writes go to the expected queue; refused ones must set the sticky flag
  task automatic cmd(input logic [7:0] s, input logic [7:0] d, input logic ok);
    int n;
    n = n_done + 1;
    apb(1'b1, REG_CMD, {16'h0000, s, d});
    if (ok) begin
      exp_q.push_back({s, d});
      wait_n(n);
    end else begin
      apb(1'b0, REG_STATUS, 32'h0);
      chk("refused", 1, rd[STAT_REFUSED_BIT]);
      apb(1'b1, REG_STATUS, 32'h20);
    end
  endtask
  task automatic sd(input logic [31:0] c, input logic [7:0] d);
    int n;
    n = n_done + 1;
    apb(1'b1, REG_CTRL, c);
    exp_q.push_back({SUB_SHUTDOWN, d});
    wait_n(n);
  endtask
  task automatic wst(input logic [3:0] s);
    for (int j = 0; j < 4000; j++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rd[3:0] === s)
        break;
    end
    chk("state", s, rd[3:0]);
  endtask
  function automatic int c13(input int t);
    return (t * 13 + 9) / 10;
  endfunction
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    supply_ok = 1'b0;
    pvdd_ok = 1'b0;
    clk_ok = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_PERIOD, 32'h0);
    chk("period_rst", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], er});
    ts = 1 + ($random(seed) & 3);
    tst = 1 + ($random(seed) & 3);
    apb(1'b1, REG_PERIOD, {16'h0000, 8'(tst), 8'(ts)});
    apb(1'b0, REG_PERIOD, 32'h0);
    chk("period_rd", {16'h0000, 8'(tst), 8'(ts)}, rd);
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_rd", 32'h1, rd);
    repeat (50) @(posedge pclk);
    chk("no_supply", 3'h0, {amp_rst_n, shutdown_n_pin, i2s_clk_en});
    supply_ok <= 1'b1;
    clk_ok <= 1'b1;
    t0 = cyc;
    for (k = 0; k < 9000 && !amp_rst_n; k++) @(posedge pclk);
    t_rel = cyc;
    chk("pre_wait", 1, t_rel - t0 >= 4000);
    chk("pre_pins", 3'h7, {amp_rst_n, shutdown_n_pin, i2s_clk_en});
    repeat (100) @(posedge pclk);
    pvdd_ok <= 1'b1;
    t_pv = cyc;
    foreach (subs[i]) cmd(subs[i], 8'($random(seed)), 1'b1);
    chk("rh_wait", 1, t_q[0] - t_rel >= RH);
    chk("pvdd_wait", 1, t_q[0] - t_pv >= 400);
    cmd(8'h30, 8'h00, 1'b0);
    cmd(SUB_SHUTDOWN, VAL_SD_ENTER, 1'b0);
    sd(32'h3, VAL_SD_EXIT);
    chk("por_wait", 1, t_q[$] - t_rel >= (240 + c13(ts)) * MS);
    wst(4'h6);
    chk("status_run", 9'h0C6, rd[8:0]);
    chk("exit_hold", 1, cyc - t_dn >= (1 + c13(ts)) * MS);
    cmd(SUB_VOL_LO, 8'($random(seed)), 1'b1);
    cmd(SUB_MUTE, 8'h01, 1'b1);
    cmd(8'h0E, 8'h00, 1'b0);
    // a clock glitch must restart the settle time before shutdown entry
    clk_ok <= 1'b0;
    repeat (20) @(posedge pclk);
    clk_ok <= 1'b1;
    t0 = cyc;
    sd(32'h1, VAL_SD_ENTER);
    chk("clk_settle", 1, t_q[$] - t0 >= 50 * MS);
    wst(4'h3);
    chk("enter_hold", 1, cyc - t_dn >= (1 + c13(tst)) * MS);
    clk_ok <= 1'b0;
    repeat (200) @(posedge pclk);
    clk_ok <= 1'b1;
    t0 = cyc;
    // a second command while one waits for auto-detect must be refused
    k = $random(seed);
    exp_q.push_back({8'h0E, 8'(k)});
    apb(1'b1, REG_CMD, {16'h0000, 8'h0E, 8'(k)});
    cmd(8'h10, 8'h00, 1'b0);
    wait_n(n_done + 1);
    chk("autodet", 1, t_q[$] - t0 >= 50 * MS);
    cmd(8'h29, 8'h00, 1'b0);
    apb(1'b0, REG_CMD, 32'h0);
    chk("cmd_rd", 32'h0000_2900, rd);
    apb(1'b1, REG_CTRL, 32'h0);
    for (k = 0; k < 300 && amp_rst_n; k++) @(posedge pclk);
    t0 = cyc;
    for (k = 0; k < 300 && shutdown_n_pin; k++) @(posedge pclk);
    chk("rl_dv", 1, cyc - t0 >= 80);
    chk("off_pins", 4'h0, {amp_rst_n, shutdown_n_pin, i2s_clk_en, i2c_req});
    chk("writes", exp_q.size(), got_q.size());
    foreach (exp_q[i]) chk("write", exp_q[i], (i < got_q.size()) ? got_q[i] : 16'hXXXX);
    chk("model", 0, viol);
    tally_and_finish();
  end
endmodule
